// ===== shared/pet_pkg.sv
// constants, types and decoder for the pending, enable and target registers
//------------------------------------------------------------------
// Contract
// [R1] mask word write clears named pending bits
// [R2] mask clear: active sources only, never level
// [R3] mask word read returns rectified source inputs
// [R4] numbered set pending; active edge sources; reads zero (code also sets detached sources)
// [R5] numbered clear pending; active edge sources; reads zero (code also clears detached sources)
// [R6] mask word write sets enables, active only
// [R7] enable mask read shows current enables
// [R8] mask word write clears enables, active only
// [R9] numbered set enable for active sources
// [R10] numbered clear enable; active, non-level sources
// [R11] second set-pending number register behaves identically
// [R12] target i at base plus 0x3004 plus 4(i-1); decoded at base plus 0x3000 plus 4i, so target 1 sits at 0x3004
// [R13] target hart field bits 31:18, resets zero
// [R14] target priority bits 7:0, resets one
// [R15] delivery enable per hart, bit 0
// [R16] force flag per hart, bit 0, resets zero
// [R17] two domains, 0x20000 apart, same offsets
// [R18] source modes 0,1,4,5,6,7; nonzero active
// [R19] numbered writes of 0 or >1023 ignored
// [R20] word-wide bus slave; write-only words read zero
//------------------------------------------------------------------
package pet_pkg;
   localparam int NUM_SRC  = 1024;                      // sources, 0 unused
   localparam int NUM_HART = 1024;                      // harts per domain
   localparam int NUM_DOM  = 2;                         // machine, supervisor
   localparam int SOURCE_PRIORITY_FIELD_LEN = 8;                        // priority bits kept
   localparam logic [18:0] M_BASE = 19'h40000;          // machine domain
   localparam logic [18:0] S_BASE = 19'h60000;          // supervisor domain
   localparam logic [15:0] OFF_IP_SET_NUM    = 16'h1CDC;
   localparam logic [15:0] OFF_IP_CLR_MASK   = 16'h1D00;
   localparam logic [15:0] OFF_IP_CLR_NUM    = 16'h1DDC;
   localparam logic [15:0] OFF_IE_SET_MASK   = 16'h1E00;
   localparam logic [15:0] OFF_IE_SET_NUM    = 16'h1EDC;
   localparam logic [15:0] OFF_IE_CLR_MASK   = 16'h1F00;
   localparam logic [15:0] OFF_IE_CLR_NUM    = 16'h1FDC;
   localparam logic [15:0] OFF_IP_SET_NUM_LE = 16'h2000;
   localparam logic [15:0] OFF_TARGET        = 16'h3004;
   localparam logic [15:0] TGT_BASE  = OFF_TARGET - 16'h0004;
   localparam logic [15:0] TGT_SPAN  = 16'h1000;        // 1024 words
   localparam logic [15:0] OFF_HART  = 16'h4000;        // delivery, hart 0
   localparam logic [15:0] OFF_FORCE = 16'h4004;        // force, hart 0
   localparam logic [4:0]  DELIV_SUB = 5'h00;           // within 0x20 stride
   localparam logic [4:0]  FORCE_SUB = 5'(OFF_FORCE - OFF_HART);
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic [7:0]  PRIO_RST  = 8'h01;
   localparam logic [7:0]  PRIO_MASK = 8'((16'h0001 << SOURCE_PRIORITY_FIELD_LEN) - 16'h0001);

   // source mode encodings
   typedef enum logic [2:0] {
      mode_inactive     = 3'b000,
      mode_detached     = 3'b001,
      rising_edge_mode  = 3'b100,
      falling_edge_mode = 3'b101,
      high_level_mode   = 3'b110,
      low_level_mode    = 3'b111
   } source_mode_field_t;

   // register kinds seen by the decoder
   typedef enum logic [3:0] {
      k_none = 4'b0000, k_ip_set_num = 4'b0001, k_ip_clr_mask = 4'b0010,
      k_ip_clr_num = 4'b0011, k_ie_set_mask = 4'b0100, k_ie_set_num = 4'b0101,
      k_ie_clr_mask = 4'b0110, k_ie_clr_num = 4'b0111, k_ip_set_num_le = 4'b1000,
      k_target = 4'b1001, k_deliv = 4'b1010, k_force = 4'b1011
   } reg_kind_t;

   typedef struct packed {
      reg_kind_t   kind;                                // which register
      logic [9:0]  idx;                                 // word, source or hart
   } dec_t;

   typedef struct packed {
      logic [13:0] destination_hart_field;              // bits 31:18
      logic [7:0]  source_priority_field;               // bits 7:0
   } target_t;

   typedef logic [NUM_DOM-1:0][NUM_SRC-1:0]       dom_bits_t;
   typedef logic [NUM_DOM-1:0][NUM_SRC-1:0][2:0]  dom_mode_t;
   typedef target_t [NUM_DOM-1:0][NUM_SRC-1:0]    dom_target_t;

   // in-domain offset to register kind and index
   function automatic dec_t decode_off(input logic [15:0] off);
      dec_t        d;
      logic [15:0] t;
      logic [15:0] h;
      d.kind = k_none;
      d.idx  = 10'h000;
      t = off - TGT_BASE;
      h = off - OFF_HART;
      if (off == OFF_IP_SET_NUM) d.kind = k_ip_set_num;
      else if (off == OFF_IP_CLR_NUM) d.kind = k_ip_clr_num;
      else if (off == OFF_IE_SET_NUM) d.kind = k_ie_set_num;
      else if (off == OFF_IE_CLR_NUM) d.kind = k_ie_clr_num;
      else if (off == OFF_IP_SET_NUM_LE) d.kind = k_ip_set_num_le;
      else if (off[15:7] == OFF_IP_CLR_MASK[15:7]) d.kind = k_ip_clr_mask;
      else if (off[15:7] == OFF_IE_SET_MASK[15:7]) d.kind = k_ie_set_mask;
      else if (off[15:7] == OFF_IE_CLR_MASK[15:7]) d.kind = k_ie_clr_mask;
      else if (t < TGT_SPAN && t[11:2] != 10'h000) d.kind = k_target;
      else if (!h[15] && h[4:0] == DELIV_SUB) d.kind = k_deliv;
      else if (!h[15] && h[4:0] == FORCE_SUB) d.kind = k_force;
      if (d.kind == k_target) d.idx = t[11:2];
      else if (d.kind == k_deliv || d.kind == k_force) d.idx = h[14:5];
      else d.idx = {5'h00, off[6:2]};
      return d;
   endfunction

   // rectified input: wire, inverted wire or zero by mode
   function automatic logic rectify(input logic [2:0] m, input logic w);
      if (m == rising_edge_mode || m == high_level_mode) return w;
      if (m == falling_edge_mode || m == low_level_mode) return ~w;
      return 1'b0;
   endfunction
endpackage

// ===== core/pend_enable_target_regs.sv
// pending, enable, target and per-hart registers for both domains
`timescale 1ns/1ps

module pend_enable_target_regs
(
   input  wire logic                 sys_clk_i,    // 50 MHz clock
   input  wire logic                 rst_n_i,      // sync reset, low
   input  wire logic                 hsel_i,       // slave select
   input  wire logic [31:0]          haddr_i,      // byte address
   input  wire logic [1:0]           htrans_i,     // transfer type
   input  wire logic                 hwrite_i,     // write when high
   input  wire logic [2:0]           hsize_i,      // transfer size
   input  wire logic [31:0]          hwdata_i,     // write data
   input  wire logic                 hready_i,     // bus ready
   output logic [31:0]               hrdata_o,     // read data
   output logic                      hreadyout_o,  // slave ready
   output logic                      hresp_o,      // always okay
   input  wire logic [pet_pkg::NUM_SRC-1:0] src_wire_i, // source wires
   input  wire pet_pkg::dom_mode_t   src_mode_i,   // mode per source
   output pet_pkg::dom_bits_t        pending_o,    // pending bits
   output pet_pkg::dom_bits_t        enable_o,     // enable bits
   output pet_pkg::dom_target_t      target_o,     // hart and priority
   output pet_pkg::dom_bits_t        delivery_o,   // per-hart delivery
   output pet_pkg::dom_bits_t        force_o       // per-hart force
);
   import pet_pkg::*;

   //---------------------------------------------------------------
   // declarations
   //---------------------------------------------------------------
   logic        a_go;          // address phase accepted
   logic        a_hit;         // address inside a domain
   logic        a_dom;         // 0 machine, 1 supervisor
   dec_t        a_dec;         // decoded address phase

   logic        ph_wr_r;       // write data phase
   logic        ph_rd_r;       // read data phase, wait cycle
   logic        ph_dom_r;      // domain of data phase
   reg_kind_t   ph_kind_r;     // register of data phase
   logic [9:0]  ph_idx_r;      // index of data phase
   logic [31:0] hrdata_r;      // registered read data
   logic [31:0] rd_nxt;        // read data being built

   logic        num_ok;        // written number in 1..1023
   logic [9:0]  num_idx;       // written source number
   logic [7:0]  prio_nxt;      // legalised priority

   dom_bits_t   act_v;         // source active
   dom_bits_t   lvl_v;         // source level sensitive
   dom_bits_t   edge_v;        // source edge sensitive
   dom_bits_t   rect;          // rectified inputs
   dom_bits_t   rect_prev_r;   // rectified inputs, last cycle
   dom_bits_t   ip_set;        // bus sets pending
   dom_bits_t   ip_clr;        // bus clears pending
   dom_bits_t   ie_set;        // bus sets enable
   dom_bits_t   ie_clr;        // bus clears enable

   dom_bits_t   pend_r;        // pending bits
   dom_bits_t   en_r;          // enable bits
   dom_target_t tgt_r;         // target registers
   dom_bits_t   deliv_r;       // delivery enables
   dom_bits_t   force_r;       // force flags

   //---------------------------------------------------------------
   // address phase decode
   //---------------------------------------------------------------

   // a transfer is taken when selected, nonseq or seq, and ready
   assign a_go  = hsel_i & htrans_i[1] & hready_i;

   // both domains share bit 18; bit 16 must be clear
   assign a_hit = (haddr_i[18] == M_BASE[18]) & ~haddr_i[16];

   // bit 17 picks the supervisor copy
   assign a_dom = (haddr_i[18:17] == S_BASE[18:17]); // R17

   // decode the offset inside the domain
   always_comb
   begin
      a_dec = decode_off(haddr_i[15:0]); // R12 R15 R16
      if (!a_hit)
      begin
         a_dec.kind = k_none;    // unmapped: no effect, reads zero
      end
   end

   //---------------------------------------------------------------
   // data phase tracking
   //---------------------------------------------------------------

   // latch the address phase; only whole words may write
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         ph_wr_r   <= 1'b0;
         ph_rd_r   <= 1'b0;
         ph_dom_r  <= 1'b0;
         ph_kind_r <= k_none;
         ph_idx_r  <= 10'h000;
      end
      else
      begin
         ph_wr_r   <= a_go & hwrite_i & (hsize_i == HSIZE_WORD); // R20
         ph_rd_r   <= a_go & ~hwrite_i;
         ph_dom_r  <= a_dom;
         ph_kind_r <= a_dec.kind;
         ph_idx_r  <= a_dec.idx;
      end
   end

   // one wait state on reads so a preceding write is seen
   assign hreadyout_o = ~ph_rd_r;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_r;

   //---------------------------------------------------------------
   // read path
   //---------------------------------------------------------------

   // select the word for the data phase
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (ph_kind_r)
         k_ip_clr_mask:
         begin
            rd_nxt = rect[ph_dom_r][{ph_idx_r[4:0], 5'h00} +: 32]; // R3
         end
         k_ie_set_mask:
         begin
            rd_nxt = en_r[ph_dom_r][{ph_idx_r[4:0], 5'h00} +: 32]; // R7
         end
         k_target:
         begin
            rd_nxt = {tgt_r[ph_dom_r][ph_idx_r].destination_hart_field,
                      10'h000,
                      tgt_r[ph_dom_r][ph_idx_r].source_priority_field}; // R13 R14
         end
         k_deliv:
         begin
            rd_nxt = {31'h0000_0000, deliv_r[ph_dom_r][ph_idx_r]}; // R15
         end
         k_force:
         begin
            rd_nxt = {31'h0000_0000, force_r[ph_dom_r][ph_idx_r]}; // R16
         end
         default:
         begin
            rd_nxt = 32'h0000_0000; // R4 R5 R20
         end
      endcase
   end

   // capture read data at the end of the wait cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         hrdata_r <= 32'h0000_0000;
      end
      else if (ph_rd_r)
      begin
         hrdata_r <= rd_nxt;
      end
   end

   //---------------------------------------------------------------
   // per-source classification and bus hits
   //---------------------------------------------------------------

   // numbers outside 1..1023 name no source
   assign num_idx = hwdata_i[9:0];
   assign num_ok  = (hwdata_i[31:10] == 22'h00_0000) && (num_idx != 10'h000); // R19

   // build mode classes and bus set/clear strobes
   always_comb
   begin
      logic [9:0] s10;
      logic       mine;
      logic       nhit;
      logic       mhit;
      s10    = 10'h000;
      mine   = 1'b0;
      nhit   = 1'b0;
      mhit   = 1'b0;
      act_v  = '0;
      lvl_v  = '0;
      edge_v = '0;
      rect   = '0;
      ip_set = '0;
      ip_clr = '0;
      ie_set = '0;
      ie_clr = '0;
      for (int d = 0; d < NUM_DOM; d++)
      begin
         for (int s = 0; s < NUM_SRC; s++)
         begin
            s10  = 10'(s);
            mine = ph_wr_r && (ph_dom_r == 1'(d));
            nhit = num_ok && (num_idx == s10);
            mhit = (ph_idx_r[4:0] == s10[9:5]) && hwdata_i[s10[4:0]];
            // nonzero mode means active; source 0 never exists
            act_v[d][s]  = (src_mode_i[d][s] != mode_inactive) && (s10 != 10'h000); // R18
            lvl_v[d][s]  = (src_mode_i[d][s] == high_level_mode) ||
                           (src_mode_i[d][s] == low_level_mode);
            edge_v[d][s] = (src_mode_i[d][s] == rising_edge_mode) ||
                           (src_mode_i[d][s] == falling_edge_mode);
            rect[d][s]   = act_v[d][s] && rectify(src_mode_i[d][s], src_wire_i[s]); // R3
            // pending set by number, both copies
            ip_set[d][s] = mine && act_v[d][s] && !lvl_v[d][s] && nhit &&
                           (ph_kind_r == k_ip_set_num || ph_kind_r == k_ip_set_num_le); // R4 R11
            // pending clear by number or by mask
            ip_clr[d][s] = mine && act_v[d][s] && !lvl_v[d][s] &&
                           ((ph_kind_r == k_ip_clr_num && nhit) ||     // R5
                            (ph_kind_r == k_ip_clr_mask && mhit));     // R1 R2
            // enable set by mask or number
            ie_set[d][s] = mine && act_v[d][s] &&
                           ((ph_kind_r == k_ie_set_mask && mhit) ||    // R6
                            (ph_kind_r == k_ie_set_num && nhit));      // R9
            // enable clear by mask or number
            ie_clr[d][s] = mine && act_v[d][s] &&
                           ((ph_kind_r == k_ie_clr_mask && mhit) ||    // R8
                            (ph_kind_r == k_ie_clr_num && nhit && !lvl_v[d][s])); // R10
         end
      end
   end

   //---------------------------------------------------------------
   // pending bits
   //---------------------------------------------------------------

   // level sources follow the rectified input; edge or bus set beats a clear
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         pend_r      <= '0;
         rect_prev_r <= '0;
      end
      else
      begin
         rect_prev_r <= rect;
         for (int d = 0; d < NUM_DOM; d++)
         begin
            for (int s = 0; s < NUM_SRC; s++)
            begin
               if (!act_v[d][s])
               begin
                  pend_r[d][s] <= 1'b0;            // inactive holds nothing
               end
               else if (lvl_v[d][s])
               begin
                  pend_r[d][s] <= rect[d][s];      // R2
               end
               else if (ip_set[d][s] ||
                        (edge_v[d][s] && rect[d][s] && !rect_prev_r[d][s]))
               begin
                  pend_r[d][s] <= 1'b1;            // R4 R11
               end
               else if (ip_clr[d][s])
               begin
                  pend_r[d][s] <= 1'b0;            // R1 R5
               end
            end
         end
      end
   end

   //---------------------------------------------------------------
   // enable bits
   //---------------------------------------------------------------

   // set wins over clear; inactive sources read disabled
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         en_r <= '0;
      end
      else
      begin
         for (int d = 0; d < NUM_DOM; d++)
         begin
            for (int s = 0; s < NUM_SRC; s++)
            begin
               if (!act_v[d][s])
               begin
                  en_r[d][s] <= 1'b0;
               end
               else if (ie_set[d][s])
               begin
                  en_r[d][s] <= 1'b1;              // R6 R9
               end
               else if (ie_clr[d][s])
               begin
                  en_r[d][s] <= 1'b0;              // R8 R10
               end
            end
         end
      end
   end

   //---------------------------------------------------------------
   // target registers
   //---------------------------------------------------------------

   // priority zero is not legal and is stored as one
   always_comb
   begin
      prio_nxt = hwdata_i[7:0] & PRIO_MASK;
      if (prio_nxt == 8'h00)
      begin
         prio_nxt = PRIO_RST;                      // R14
      end
   end

   // hart field and priority per source
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int d = 0; d < NUM_DOM; d++)
         begin
            for (int s = 0; s < NUM_SRC; s++)
            begin
               tgt_r[d][s].destination_hart_field <= 14'h0000; // R13
               tgt_r[d][s].source_priority_field  <= PRIO_RST; // R14
            end
         end
      end
      else if (ph_wr_r && ph_kind_r == k_target)
      begin
         tgt_r[ph_dom_r][ph_idx_r].destination_hart_field <= hwdata_i[31:18]; // R13
         tgt_r[ph_dom_r][ph_idx_r].source_priority_field  <= prio_nxt;        // R14
      end
   end

   //---------------------------------------------------------------
   // per-hart delivery and force
   //---------------------------------------------------------------

   // bit 0 only; other bits read zero
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         deliv_r <= '0;
         force_r <= '0;
      end
      else if (ph_wr_r && ph_kind_r == k_deliv)
      begin
         deliv_r[ph_dom_r][ph_idx_r] <= hwdata_i[0]; // R15
      end
      else if (ph_wr_r && ph_kind_r == k_force)
      begin
         force_r[ph_dom_r][ph_idx_r] <= hwdata_i[0]; // R16
      end
   end

   //---------------------------------------------------------------
   // outputs to the rest of the controller
   //---------------------------------------------------------------

   assign pending_o  = pend_r;
   assign enable_o   = en_r;
   assign target_o   = tgt_r;
   assign delivery_o = deliv_r;
   assign force_o    = force_r;

endmodule // pend_enable_target_regs

// ===== tb/pet_checker_assertions.sv
// bus timing, reset value and pending behaviour checker for the register block
`timescale 1ns/1ps

module pet_checker
   import pet_pkg::*;
(
   input wire logic                          sys_clk_i,   // clock
   input wire logic                          rst_n_i,     // sync reset, low
   input wire logic                          hsel_i,      // select
   input wire logic [1:0]                    htrans_i,    // transfer type
   input wire logic                          hwrite_i,    // write
   input wire logic                          hready_i,    // bus ready
   input wire logic [31:0]                   hrdata_o,    // read data
   input wire logic                          hreadyout_o, // slave ready
   input wire logic                          hresp_o,     // response
   input wire logic [pet_pkg::NUM_SRC-1:0]   src_wire_i,  // source wires
   input wire pet_pkg::dom_mode_t            src_mode_i,  // source modes
   input wire pet_pkg::dom_bits_t            pending_o,   // pending bits
   input wire pet_pkg::dom_bits_t            enable_o,    // enable bits
   input wire pet_pkg::dom_target_t          target_o     // targets
);
   //------
   // bus transfers taken and the source 7 rising edge
   //------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd;
      hsel_i && htrans_i[1] && hready_i && !hwrite_i;
   endsequence
   sequence s_wr;
      hsel_i && htrans_i[1] && hready_i && hwrite_i;
   endsequence
   sequence s_rise7;
      (src_mode_i[0][7] == 3'h4)[*2] ##0 $rose(src_wire_i[7]);
   endsequence
   //------
   // properties
   //------
   a_read_one_wait: assert property (s_rd |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait is not exactly one cycle");
   a_write_no_wait: assert property (s_wr |=> hreadyout_o)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp_o == 1'b0)
      else $error("response is not okay");
   a_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
      else $error("read data moved outside a read");
   a_reset_values: assert property ($rose(rst_n_i) |-> target_o[0][1] == 22'h000001 && pending_o == '0)
      else $error("reset values wrong");
   a_level_follow: assert property ((src_mode_i[0][3] == 3'h6 && $past(rst_n_i))[*2]
                                     |-> pending_o[0][3] == $past(src_wire_i[3]))
      else $error("level source pending does not follow wire");
   a_inactive_zero: assert property ((src_mode_i[0][2] == 3'h0)[*2] |-> !pending_o[0][2] && !enable_o[0][2])
      else $error("inactive source holds state");
   a_edge_sets: assert property (s_rise7 |-> ##[1:2] pending_o[0][7])
      else $error("rising edge did not set pending");
   a_prio_nonzero: assert property (target_o[0][5].source_priority_field != 8'h00)
      else $error("priority zero stored");
endmodule // pet_checker

bind pend_enable_target_regs pet_checker i_pet_checker (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .src_wire_i(src_wire_i), .src_mode_i(src_mode_i),
   .pending_o(pending_o), .enable_o(enable_o), .target_o(target_o));

// ===== tb/src_side_model.sv
// model of the interrupt source side: registered wires and per-domain modes
`timescale 1ns/1ps

module src_side_model
   import pet_pkg::*;
(
   input  wire logic                        clk_i,   // clock
   input  wire logic [pet_pkg::NUM_SRC-1:0] wire_i,  // wanted wire levels
   input  wire pet_pkg::dom_mode_t          mode_i,  // wanted modes
   output logic [pet_pkg::NUM_SRC-1:0]      wire_o,  // source wires
   output pet_pkg::dom_mode_t               mode_o   // source modes
);
   // wires and modes change only just after an edge, like real flops
   always_ff @(posedge clk_i)
   begin
      wire_o <= wire_i;
      mode_o <= mode_i;
   end
endmodule // src_side_model

// ===== tb/tb_aplic_pending_enable_target_regs.sv
// self-checking bench for the pending, enable and target registers
`timescale 1ns/1ps

module tb_aplic_pending_enable_target_regs;
   import pet_pkg::*;
   logic               sys_clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, rd_dp;
   logic [1:0]         htrans_i;
   logic [2:0]         hsize_i;
   logic [31:0]        haddr_i, hwdata_i, hrdata_o, d, e;
   logic [15:0]        seed;
   logic [NUM_SRC-1:0] wire_set, src_wire;
   dom_mode_t          mode_set, src_mode;
   dom_bits_t          pending_o, enable_o, delivery_o, force_o;
   dom_target_t        target_o;
   logic [31:0]        exp_q[$];                         // expected read data
   logic [2:0]         m [8] = '{3'h0, 3'h1, 3'h0, 3'h6, 3'h4, 3'h5, 3'h7, 3'h4};
   int                 n_mismatch = 0, check_count = 0;

   pend_enable_target_regs i_pend_enable_target_regs (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .src_wire_i(src_wire), .src_mode_i(src_mode), .pending_o(pending_o), .enable_o(enable_o),
      .target_o(target_o), .delivery_o(delivery_o), .force_o(force_o));
   src_side_model i_src_side_model (.clk_i(sys_clk_i), .wire_i(wire_set), .mode_i(mode_set),
      .wire_o(src_wire), .mode_o(src_mode));

   //------
   // helpers
   //------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for ready sampled high at a rising edge, bounded
   task automatic wt;
      for (int i = 0; i < 20; i++)
      begin
         @(posedge sys_clk_i);
         if (hreadyout_o === 1'b1)
            return;
      end
      n_mismatch++;
      end_sim;
   endtask
   task automatic xf(input logic [31:0] a, input logic w, input logic [31:0] dat, input logic [2:0] sz);
      @(posedge sys_clk_i);
      hsel_i   <= 1'b1;
      haddr_i  <= a;
      htrans_i <= 2'b10;
      hwrite_i <= w;
      hsize_i  <= sz;
      wt;
      hsel_i   <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= dat;
      wt;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] dat);
      xf(a, 1'b1, dat, HSIZE_WORD);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      xf(a, 1'b0, 32'h0, HSIZE_WORD);
   endtask
   function automatic logic [15:0] lf(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd(output logic [31:0] r);
      seed = lf(seed);
      r[31:16] = seed;
      seed = lf(seed);
      r[15:0] = seed;
   endtask

   //------
   // clock and read data monitor
   //------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // compares read data at the edge that ends each read data phase
   always @(posedge sys_clk_i)
      if (hreadyout_o === 1'b1)
      begin
         if (rd_dp)
            chk(hrdata_o, exp_q.pop_front());
         rd_dp = hsel_i && htrans_i[1] && !hwrite_i && rst_n_i;
      end

   //------
   // main sequence
   //------
   initial
   begin
      {hsel_i, hwrite_i, htrans_i, hsize_i, haddr_i, hwdata_i, rst_n_i} = '0;
      wire_set = '0;
      mode_set = '0;
      seed = 16'h59B6;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      for (int j = 0; j < 8; j++)
         mode_set[0][j] <= m[j];
      for (int j = 32; j < 64; j++)
         mode_set[0][j] <= 3'h4;
      mode_set[1][33] <= 3'h4;
      wire_set[7:0] <= 8'h7A;
      repeat (3) @(posedge sys_clk_i);
      rd(32'h43004, 32'h1);
      rd(32'h44060, 32'h0);
      rd(32'h44064, 32'h0);
      // wires 0x7A: high level 3 and rising 4 show one
      rd(32'h41D00, 32'h18);
      wr(32'h41E00, '1);
      rd(32'h41E00, 32'hFA);
      rnd(d);
      wr(32'h41E04, d);
      rd(32'h41E04, d);
      rnd(e);
      wr(32'h41F04, e);
      rd(32'h41E04, d & ~e);
      rd(32'h41F04, 32'h0);
      xf(32'h41F04, 1'b1, '1, 3'h0);
      rd(32'h41E04, d & ~e);
      wr(32'h61E04, '1);
      rd(32'h61E04, 32'h2);
      wr(32'h41FDC, 32'd3);
      wr(32'h41FDC, 32'd4);
      wr(32'h41FDC, 32'd1031);
      wr(32'h41EDC, 32'd0);
      wr(32'h41EDC, 32'd40);
      @(negedge sys_clk_i);
      chk(32'(enable_o[0][7:0]), 32'hEA);
      chk(32'(enable_o[0][40]), 32'h1);
      wr(32'h41CDC, 32'd7);
      wr(32'h42000, 32'd1);
      wr(32'h41CDC, 32'd2);
      wr(32'h41CDC, 32'd6);
      @(negedge sys_clk_i);
      chk(32'({pending_o[0][7:5], pending_o[0][3:0]}), 32'h4A);
      wr(32'h41DDC, 32'd7);
      wr(32'h41D00, 32'h0000000A);
      @(negedge sys_clk_i);
      chk(32'({pending_o[0][7:5], pending_o[0][3:0]}), 32'h08);
      rd(32'h41CDC, 32'h0);
      rd(32'h41DDC, 32'h0);
      rd(32'h42000, 32'h0);
      wire_set[7] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      chk(32'(pending_o[0][7]), 32'h1);
      wr(32'h43014, {14'h2AB, 10'h3FF, 8'h00});
      rd(32'h43014, {14'h2AB, 10'h000, 8'h01});
      rnd(d);
      wr(32'h43FFC, d);
      rd(32'h43FFC, {d[31:18], 10'h000, (d[7:0] == 8'h00) ? 8'h01 : d[7:0]});
      wr(32'h44060, '1);
      wr(32'h64064, '1);
      rd(32'h44060, 32'h1);
      rd(32'h64064, 32'h1);
      chk(32'({delivery_o[0][3], force_o[1][3], force_o[0][3]}), 32'h6);
      rd(32'h40100, 32'h0);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      rd(32'h43014, 32'h1);
      @(negedge sys_clk_i);
      chk(32'(exp_q.size()), 32'h0);
      end_sim;
   end
endmodule // tb_aplic_pending_enable_target_regs
